// ==== rtl/sfpec_pkg.sv ====
package sfpec_pkg;
  localparam int CLK_MHZ = 20;
  // Half period of the serial clock made by the host, in system cycles
  localparam int SCK_HALF_CYC = 4;

  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_PP     = 8'h02;
  localparam logic [7:0] OP_FPP    = 8'hF2;
  localparam logic [7:0] OP_SE     = 8'h20;
  localparam logic [7:0] OP_BE32   = 8'h52;
  localparam logic [7:0] OP_BE64   = 8'hD8;
  localparam logic [7:0] OP_CE_A   = 8'hC7;
  localparam logic [7:0] OP_CE_B   = 8'h60;
  localparam logic [7:0] OP_SUSP   = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;

  localparam int PAGE_PROGRAM_TIME_US = 1000;
  localparam int SECTOR_ERASE_TIME_MS = 100;
  localparam int BLOCK_ERASE_TIME_MS  = 300;
  localparam int CHIP_ERASE_TIME_MS   = 2000;
  localparam int PP_CYCLES = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int SE_CYCLES = SECTOR_ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int BE_CYCLES = BLOCK_ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int CE_CYCLES = CHIP_ERASE_TIME_MS * 1000 * CLK_MHZ;

  // Region sizes minus one
  localparam logic [16:0] LEN_PAGE_M1 = 17'h000FF;
  localparam logic [16:0] LEN_SECT_M1 = 17'h00FFF;
  localparam logic [16:0] LEN_B32_M1  = 17'h07FFF;
  localparam logic [16:0] LEN_B64_M1  = 17'h0FFFF;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;

  // Protection covers the top of the array, one sector doubled per step
  localparam logic [24:0] PROT_UNIT   = 25'h0001000;
  localparam logic [24:0] PROT_TOP    = 25'h1000000;
  localparam logic [4:0]  PROT_ALL_BP = 5'h0D;

  localparam logic [1:0] REG_CMD  = 2'h0;
  localparam logic [1:0] REG_ADDR = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_ADDR_BIT = 8;
  localparam int CMD_LEN_LSB  = 9;
  localparam int CMD_XB_LSB   = 18;

  typedef enum logic [2:0] {
    K_PROG, K_SECT, K_B32, K_B64, K_CHIP
  } sfpec_kind_t;
endpackage

// ==== rtl/sfpec_link_if.sv ====
`timescale 1ns/1ps
interface sfpec_link_if;
  logic csN;
  logic sck;
  logic mosi;

  modport host (
    output csN,
    output sck,
    output mosi
  );
  modport flash (
    input csN,
    input sck,
    input mosi
  );
endinterface

// ==== rtl/sfpec_device.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Program needs write-enable latch set first
// - Host sends F2h, address, data bytes
// - Data past page end wraps to page start
// - Over 256 bytes: last 256 kept
// - Short program leaves other page bytes
// - Program needs chip select on byte boundary
// - Chip select rise starts timed program
// - Progress flag during cycle; latch cleared
// - Protected page is not programmed
// - Sector erase 20h, any address inside
// - Erase needs rise after address byte
// - Sector erase timed, skipped if protected
// - 52h erases 32 kB block unless protected
// - D8h erases 64 kB block unless protected
// - C7h or 60h erase whole array
// - Chip erase aligned, unprotected, latch cleared
// - 75h suspends sector or block erase, or program
// - Erase suspend rejects further erase commands
// - Program suspend rejects program commands
// - Host limits suspend and resume repeats
// - Resume only when suspended and idle
// - Resume clears suspend, restarts progress
module sfpec_device
  import sfpec_pkg::*;
#(
  parameter int MEM_AW = 16,
  parameter int PP_CYC = PP_CYCLES,
  parameter int SE_CYC = SE_CYCLES,
  parameter int BE_CYC = BE_CYCLES,
  parameter int CE_CYC = CE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  sfpec_link_if.flash            link,
  input  wire logic [4:0]        blockProtect,
  input  wire logic [MEM_AW-1:0] memRdAddr,
  output logic      [7:0]        memRdData,
  output logic                   writeEnableLatch,
  output logic                   writeInProgress,
  output logic                   suspendFlag
);
  typedef enum logic [1:0] {DS_IDLE, DS_WORK, DS_TIMER} sfpec_dstate_t;
  // Regions larger than the array alias onto it; one pass covers them
  localparam logic [16:0] MEM_LAST = 17'((2**MEM_AW) - 1);

  logic [2:0]        meta_ff, sync_ff, prev_ff;
  logic [7:0]        shReg_ff, opcode_ff, dataIdx_ff, memRdData_ff;
  logic [2:0]        bitCnt_ff, byteCnt_ff;
  logic [23:0]       addr_ff, base_ff;
  logic [255:0]      pageMask_ff;
  logic [7:0]        pageBuf [256];
  logic [7:0]        mem [2**MEM_AW];
  sfpec_dstate_t     state_ff;
  sfpec_kind_t       kind_ff, savedKind_ff, kindSel;
  logic [31:0]       timer_ff, savedTimer_ff, cycSel;
  logic [16:0]       workIdx_ff, workLast_ff, lenM1;
  logic              wrEn_ff, busy_ff, paused_ff;
  logic              csN, csRise, csFall, sckRise, byteDone, aligned;
  logic              startOk, protHit, go, suspendReq, resumeReq;
  logic              welSet, welClr, doneNow, capture;
  logic [7:0]        newByte, col;
  logic [23:0]       regionBase;
  logic [23:0]       wrSum;

  function automatic logic isProt(input logic [23:0] hi,
                                  input logic [4:0]  bp);
    logic [24:0] protLo;
    protLo = PROT_TOP;
    if (bp >= PROT_ALL_BP)
      protLo = 25'h0000000;
    else if (bp != 5'h00)
      protLo = PROT_TOP - (PROT_UNIT << (bp - 5'h01));
    return (bp != 5'h00) && ({1'b0, hi} >= protLo);
  endfunction

  // Pins come from the host's domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 3'h4;
      sync_ff <= 3'h4;
      prev_ff <= 3'h4;
    end else begin
      meta_ff <= {link.csN, link.sck, link.mosi};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign csN      = sync_ff[2];
  assign csRise   = sync_ff[2] & ~prev_ff[2];
  assign csFall   = ~sync_ff[2] & prev_ff[2];
  assign sckRise  = ~csN & sync_ff[1] & ~prev_ff[1];
  assign newByte  = {shReg_ff[6:0], sync_ff[0]};
  assign byteDone = sckRise && (bitCnt_ff == 3'h7);
  assign aligned  = (bitCnt_ff == 3'h0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shReg_ff   <= 8'h00;
      bitCnt_ff  <= 3'h0;
      byteCnt_ff <= 3'h0;
      opcode_ff  <= 8'h00;
      addr_ff    <= 24'h000000;
    end else if (csFall) begin
      bitCnt_ff  <= 3'h0;
      byteCnt_ff <= 3'h0;
    end else if (sckRise) begin
      shReg_ff  <= newByte;
      bitCnt_ff <= bitCnt_ff + 3'h1;
      if (byteDone) begin
        if (byteCnt_ff != 3'h5)
          byteCnt_ff <= byteCnt_ff + 3'h1;
        if (byteCnt_ff == 3'h0)
          opcode_ff <= newByte;
        else if (byteCnt_ff <= 3'h3)
          addr_ff <= {addr_ff[15:0], newByte};
      end
    end
  end

  // Page buffer is frozen while its contents are being written out
  assign col     = addr_ff[7:0] + dataIdx_ff;
  assign capture = byteDone && (byteCnt_ff >= 3'h4) &&
                   (state_ff != DS_WORK);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pageMask_ff <= '0;
      dataIdx_ff  <= 8'h00;
    end else if (csFall && state_ff != DS_WORK) begin
      pageMask_ff <= '0;
      dataIdx_ff  <= 8'h00;
    end else if (capture) begin
      pageMask_ff[col] <= 1'b1;
      dataIdx_ff       <= dataIdx_ff + 8'h01;
    end else if (state_ff == DS_WORK && workIdx_ff == workLast_ff) begin
      pageMask_ff <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (capture)
      pageBuf[col] <= newByte;
  end

  always_comb begin
    startOk = 1'b0;
    kindSel = K_PROG;
    lenM1   = LEN_PAGE_M1;
    cycSel  = 32'(PP_CYC);
    unique case (opcode_ff)
      OP_PP, OP_FPP: begin
        startOk = (byteCnt_ff == 3'h5) &&
                  !(paused_ff && savedKind_ff == K_PROG);
      end
      OP_SE: begin
        kindSel = K_SECT;
        lenM1   = LEN_SECT_M1;
        cycSel  = 32'(SE_CYC);
        startOk = (byteCnt_ff == 3'h4) &&
                  !(paused_ff && savedKind_ff != K_PROG);
      end
      OP_BE32: begin
        kindSel = K_B32;
        lenM1   = LEN_B32_M1;
        cycSel  = 32'(BE_CYC);
        startOk = (byteCnt_ff == 3'h4) && !paused_ff;
      end
      OP_BE64: begin
        kindSel = K_B64;
        lenM1   = LEN_B64_M1;
        cycSel  = 32'(BE_CYC);
        startOk = (byteCnt_ff == 3'h4) &&
                  !(paused_ff && savedKind_ff != K_PROG);
      end
      OP_CE_A, OP_CE_B: begin
        kindSel = K_CHIP;
        lenM1   = 17'((2**MEM_AW) - 1);
        cycSel  = 32'(CE_CYC);
        startOk = (byteCnt_ff == 3'h1) && !paused_ff;
      end
      default: startOk = 1'b0;
    endcase
  end

  assign regionBase = (kindSel == K_CHIP) ? 24'h000000 :
                      (addr_ff & ~{7'h00, lenM1});
  assign protHit = (kindSel == K_CHIP) ? (blockProtect != 5'h00) :
                   isProt(regionBase + {7'h00, lenM1},
                          blockProtect);
  assign go = csRise && aligned && startOk && wrEn_ff && !busy_ff &&
              !protHit;
  assign suspendReq = csRise && aligned && (byteCnt_ff == 3'h1) &&
                      (opcode_ff == OP_SUSP) && (state_ff == DS_TIMER) &&
                      (kind_ff != K_CHIP) && !paused_ff;
  assign resumeReq = csRise && aligned && (byteCnt_ff == 3'h1) &&
                     (opcode_ff == OP_RESUME) && paused_ff &&
                     !busy_ff;
  assign doneNow = (state_ff == DS_TIMER) && !suspendReq &&
                   (timer_ff <= 32'h1);

  // Memory is updated before the timed wait; the wait covers both
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff    <= DS_IDLE;
      busy_ff     <= 1'b0;
      kind_ff     <= K_PROG;
      base_ff     <= 24'h000000;
      workIdx_ff  <= 17'h00000;
      workLast_ff <= 17'h00000;
      timer_ff    <= 32'h0;
    end else begin
      unique case (state_ff)
        DS_IDLE: begin
          if (go) begin
            state_ff    <= DS_WORK;
            busy_ff     <= 1'b1;
            kind_ff     <= kindSel;
            base_ff     <= regionBase;
            workIdx_ff  <= 17'h00000;
            workLast_ff <= (lenM1 > MEM_LAST) ? MEM_LAST : lenM1;
            timer_ff    <= cycSel;
          end else if (resumeReq) begin
            state_ff <= DS_TIMER;
            busy_ff  <= 1'b1;
            kind_ff  <= savedKind_ff;
            timer_ff <= savedTimer_ff;
          end
        end
        DS_WORK: begin
          workIdx_ff <= workIdx_ff + 17'h00001;
          if (timer_ff > 32'h1)
            timer_ff <= timer_ff - 32'h1;
          if (workIdx_ff == workLast_ff)
            state_ff <= DS_TIMER;
        end
        DS_TIMER: begin
          if (suspendReq || doneNow) begin
            state_ff <= DS_IDLE;
            busy_ff  <= 1'b0;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      paused_ff     <= 1'b0;
      savedKind_ff  <= K_PROG;
      savedTimer_ff <= 32'h0;
    end else if (suspendReq) begin
      paused_ff     <= 1'b1;
      savedKind_ff  <= kind_ff;
      savedTimer_ff <= timer_ff;
    end else if (resumeReq) begin
      paused_ff <= 1'b0;
    end
  end

  assign welSet = csRise && aligned && (byteCnt_ff == 3'h1) &&
                  (opcode_ff == OP_WREN) && !busy_ff;
  // Chip erase keeps the latch until its cycle has finished
  assign welClr = (csRise && aligned && (byteCnt_ff == 3'h1) &&
                   (opcode_ff == OP_WRDI) && !busy_ff) ||
                  (go && kindSel != K_CHIP) ||
                  (doneNow && kind_ff == K_CHIP);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      wrEn_ff <= 1'b0;
    else if (welSet)
      wrEn_ff <= 1'b1;
    else if (welClr)
      wrEn_ff <= 1'b0;
  end

  assign wrSum = base_ff + {7'h00, workIdx_ff};

  always_ff @(posedge clk) begin
    if (state_ff == DS_WORK) begin
      if (kind_ff != K_PROG)
        mem[wrSum[MEM_AW-1:0]] <= ERASED_BYTE;
      else if (pageMask_ff[workIdx_ff[7:0]])
        mem[wrSum[MEM_AW-1:0]] <= pageBuf[workIdx_ff[7:0]];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      memRdData_ff <= 8'h00;
    else
      memRdData_ff <= mem[memRdAddr];
  end

  assign memRdData        = memRdData_ff;
  assign writeEnableLatch = wrEn_ff;
  assign writeInProgress  = busy_ff;
  assign suspendFlag      = paused_ff;
endmodule

// ==== rtl/sfpec_host.sv ====
`timescale 1ns/1ps
module sfpec_host
  import sfpec_pkg::*;
#(
  parameter int HALF_CYC = SCK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  sfpec_link_if.host       link,
  input  wire logic [1:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata
);
  typedef enum logic [2:0] {
    HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_TAIL, HS_GAP
  } sfpec_hstate_t;

  sfpec_hstate_t state_ff;
  logic [7:0]    opcode_ff, wrPtr_ff, shReg_ff;
  logic          hasAddr_ff, csN_ff, sck_ff, mosi_ff;
  logic [8:0]    dataLen_ff;
  logic [2:0]    extraBits_ff, bitInByte_ff;
  logic [23:0]   addr_ff;
  logic [7:0]    dataMem [256];
  logic [31:0]   regRdata_ff;
  logic [15:0]   div_ff;
  logic [12:0]   bitsLeft_ff, totalBits;
  logic [9:0]    byteNo_ff;
  logic          halfTick, startCmd;
  logic [7:0]    followByte;

  function automatic logic [7:0] byteAt(input logic [9:0] n);
    logic [9:0] d;
    d = n - (hasAddr_ff ? 10'h004 : 10'h001);
    if (n == 10'h000)
      return opcode_ff;
    if (hasAddr_ff && n <= 10'h003)
      return addr_ff[8'(10'h003 - n) * 8 +: 8];
    return dataMem[d[7:0]];
  endfunction

  assign startCmd  = regWr && regAddr == REG_CMD && state_ff == HS_IDLE;
  assign totalBits = 13'h008 + (regWdata[CMD_ADDR_BIT] ? 13'h018 : 13'h000)
                   + {1'b0, regWdata[CMD_LEN_LSB +: 9], 3'h0}
                   + {10'h000, regWdata[CMD_XB_LSB +: 3]};
  assign halfTick  = (div_ff == 16'(HALF_CYC - 1));
  assign followByte = byteAt(byteNo_ff + 10'h001);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opcode_ff    <= 8'h00;
      hasAddr_ff   <= 1'b0;
      dataLen_ff   <= 9'h000;
      extraBits_ff <= 3'h0;
      addr_ff      <= 24'h000000;
      wrPtr_ff     <= 8'h00;
    end else if (regWr) begin
      if (startCmd) begin
        opcode_ff    <= regWdata[CMD_OP_LSB +: 8];
        hasAddr_ff   <= regWdata[CMD_ADDR_BIT];
        dataLen_ff   <= regWdata[CMD_LEN_LSB +: 9];
        extraBits_ff <= regWdata[CMD_XB_LSB +: 3];
      end else if (regAddr == REG_ADDR) begin
        addr_ff  <= regWdata[23:0];
        wrPtr_ff <= 8'h00;
      end else if (regAddr == REG_DATA) begin
        wrPtr_ff <= wrPtr_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (regWr && regAddr == REG_DATA)
      dataMem[wrPtr_ff] <= regWdata[7:0];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      regRdata_ff <= 32'h0;
    else if (regRd) begin
      unique case (regAddr)
        REG_CMD:  regRdata_ff <= {11'h000, extraBits_ff, dataLen_ff,
                                  hasAddr_ff, opcode_ff};
        REG_ADDR: regRdata_ff <= {8'h00, addr_ff};
        REG_DATA: regRdata_ff <= {24'h000000, wrPtr_ff};
        REG_STAT: regRdata_ff <= {31'h0, state_ff != HS_IDLE};
      endcase
    end
  end

  // Half-period enable; restarts with each frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      div_ff <= 16'h0000;
    else if (state_ff == HS_IDLE || halfTick)
      div_ff <= 16'h0000;
    else
      div_ff <= div_ff + 16'h0001;
  end

  // Chip select stays low for the whole frame; data moves on falling sck
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= HS_IDLE;
      csN_ff       <= 1'b1;
      sck_ff       <= 1'b0;
      mosi_ff      <= 1'b0;
      shReg_ff     <= 8'h00;
      bitsLeft_ff  <= 13'h0000;
      byteNo_ff    <= 10'h000;
      bitInByte_ff <= 3'h0;
    end else begin
      unique case (state_ff)
        HS_IDLE: if (startCmd) begin
          state_ff     <= HS_LEAD;
          csN_ff       <= 1'b0;
          shReg_ff     <= regWdata[CMD_OP_LSB +: 8];
          mosi_ff      <= regWdata[CMD_OP_LSB + 7];
          bitsLeft_ff  <= totalBits;
          byteNo_ff    <= 10'h000;
          bitInByte_ff <= 3'h0;
        end
        HS_LEAD: if (halfTick)
          state_ff <= HS_LOW;
        HS_LOW: if (halfTick) begin
          sck_ff   <= 1'b1;
          state_ff <= HS_HIGH;
        end
        HS_HIGH: if (halfTick) begin
          sck_ff       <= 1'b0;
          bitsLeft_ff  <= bitsLeft_ff - 13'h0001;
          bitInByte_ff <= bitInByte_ff + 3'h1;
          if (bitInByte_ff == 3'h7) begin
            byteNo_ff <= byteNo_ff + 10'h001;
            shReg_ff  <= followByte;
            mosi_ff   <= followByte[7];
          end else begin
            shReg_ff <= {shReg_ff[6:0], 1'b0};
            mosi_ff  <= shReg_ff[6];
          end
          state_ff <= (bitsLeft_ff == 13'h0001) ? HS_TAIL : HS_LOW;
        end
        HS_TAIL: if (halfTick) begin
          csN_ff   <= 1'b1;
          state_ff <= HS_GAP;
        end
        HS_GAP: if (halfTick)
          state_ff <= HS_IDLE;
      endcase
    end
  end

  assign link.csN  = csN_ff;
  assign link.sck  = sck_ff;
  assign link.mosi = mosi_ff;
  assign regRdata  = regRdata_ff;
endmodule

// ==== testbench/sfpec_link_properties.sv ====
`timescale 1ns/1ps
module sfpec_link_properties
  import sfpec_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       csN,
  input wire logic       sck,
  input wire logic       mosi,
  input wire logic [4:0] blockProtect,
  input wire logic       writeEnableLatch,
  input wire logic       writeInProgress,
  input wire logic       suspendFlag
);
  logic       csPrev_ff;
  logic [3:0] sinceCs_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) csPrev_ff <= 1'b1;
    else csPrev_ff <= csN;
  end

  // Saturates so a long idle never wraps back into the window
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) sinceCs_ff <= 4'hF;
    else if (csN && !csPrev_ff) sinceCs_ff <= 4'h0;
    else if (sinceCs_ff != 4'hF) sinceCs_ff <= sinceCs_ff + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence sCmdEnd;
    sinceCs_ff inside {[4'h1:4'h6]};
  endsequence
  sequence sResumed;
    $rose(writeInProgress) && !suspendFlag;
  endsequence
  sequence sSuspended;
    $fell(writeInProgress) ##0 sCmdEnd;
  endsequence

  a_sck_idle_low: assert property (csN |-> !sck)
    else $error("serial clock not low outside frame");
  a_sck_half_period: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("serial clock high phase has wrong length");
  a_mosi_stable_high: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("data line moved while clock high");
  a_cycle_start_cs: assert property ($rose(writeInProgress) |-> sCmdEnd)
    else $error("progress flag rose away from chip select rise");
  a_latch_set_cs: assert property ($rose(writeEnableLatch) |-> sCmdEnd)
    else $error("write enable latch set away from chip select rise");
  a_start_needs_latch: assert property ($rose(writeInProgress) &&
    !$past(suspendFlag) |-> $past(writeEnableLatch))
    else $error("cycle started without write enable latch");
  a_done_latch_clear: assert property ($fell(writeInProgress)
    |-> !writeEnableLatch)
    else $error("write enable latch still set at end of cycle");
  a_resume_swap: assert property ($fell(suspendFlag) |-> sResumed)
    else $error("resume did not restart progress flag");
  a_resume_idle: assert property ($fell(suspendFlag) |->
    !$past(writeInProgress))
    else $error("suspend flag cleared while a cycle was running");
  a_suspend_enter: assert property ($rose(suspendFlag) |-> sSuspended)
    else $error("suspend flag rose without halting the cycle");
  a_protect_all: assert property ($rose(writeInProgress) &&
    !$past(suspendFlag) |-> blockProtect < PROT_ALL_BP)
    else $error("cycle started with whole array protected");
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import sfpec_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [1:0]  regAddr = 2'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdata;
  logic [4:0]  blockProtect = 5'h00;
  logic [11:0] memRdAddr = 12'h000;
  logic [7:0]  memRdData;
  logic        writeEnableLatch;
  logic        writeInProgress;
  logic        suspendFlag;
  int          mismatches = 0;
  int          num_checks = 0;

  always #25 clk = ~clk;

  sfpec_link_if link ();

  sfpec_host sfpec_host_inst (
    .clk(clk), .arst_n(arst_n), .link(link), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata)
  );

  // Short timers; erase work is bounded by the 4 KB array
  sfpec_device #(.MEM_AW(12), .PP_CYC(600), .SE_CYC(8000),
    .BE_CYC(5000), .CE_CYC(5000)) sfpec_device_inst (
    .clk(clk), .arst_n(arst_n), .link(link),
    .blockProtect(blockProtect), .memRdAddr(memRdAddr),
    .memRdData(memRdData), .writeEnableLatch(writeEnableLatch),
    .writeInProgress(writeInProgress), .suspendFlag(suspendFlag)
  );

  sfpec_link_properties sfpec_link_properties_inst (
    .clk(clk), .arst_n(arst_n), .csN(link.csN), .sck(link.sck),
    .mosi(link.mosi), .blockProtect(blockProtect),
    .writeEnableLatch(writeEnableLatch),
    .writeInProgress(writeInProgress), .suspendFlag(suspendFlag)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [31:0] fl();
    return 32'({writeEnableLatch, writeInProgress, suspendFlag});
  endfunction

  task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rdm(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    memRdAddr <= a;
    repeat (2) @(posedge clk);
    #1 v = 32'(memRdData);
  endtask

  // Extra bits past the data push the chip select rise off a byte edge
  task automatic cmd(input logic [7:0] op, input logic ha,
                     input logic [23:0] a, input int n,
                     input logic [2:0] xb);
    logic [31:0] d;
    int          k;
    reg_wr(REG_ADDR, {8'h00, a});
    for (k = 0; k < n + (xb != 3'h0); k++) begin
      reg_wr(REG_DATA, 32'(8'hA0 + k[7:0]));
    end
    reg_wr(REG_CMD, 32'({xb, 9'(n), ha, op}));
    d = 32'h1;
    k = 0;
    while (d[0] !== 1'b0) begin
      reg_rd(REG_STAT, d);
      k++;
      if (k > 3000) begin
        mismatches++;
        wrap_up();
      end
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (writeInProgress !== 1'b0) begin
      @(posedge clk);
      k++;
      if (k > 20000) begin
        mismatches++;
        wrap_up();
      end
    end
  endtask

  task automatic t_erase;
    logic [7:0]  ops [5];
    logic [31:0] v;
    int          i;
    ops = '{OP_SE, OP_BE32, OP_BE64, OP_CE_A, OP_CE_B};
    for (i = 0; i < 5; i++) begin
      if (i > 0) begin
        cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
        cmd(OP_FPP, 1'b1, 24'h000010, 1, 3'h0);
        wait_idle();
        rdm(12'h010, v);
        check(v, 32'hA0);
      end
      cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
      cmd(ops[i], i < 3, 24'h000010, 0, 3'h0);
      check(fl(), (i >= 3) ? 32'h6 : 32'h2);
      wait_idle();
      check(fl(), 32'h0);
      rdm(12'h010, v);
      check(v, 32'(ERASED_BYTE));
    end
    $display("erase test done");
  endtask

  task automatic t_prog;
    logic [31:0] v;
    cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_FPP, 1'b1, 24'h0000FE, 4, 3'h0);
    check(fl(), 32'h2);
    wait_idle();
    rdm(12'h0FE, v);
    check(v, 32'hA0);
    rdm(12'h000, v);
    check(v, 32'hA2);
    rdm(12'h001, v);
    check(v, 32'hA3);
    rdm(12'h002, v);
    check(v, 32'hFF);
    rdm(12'h100, v);
    check(v, 32'hFF);
    cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_FPP, 1'b1, 24'h000300, 2, 3'h3);
    check(fl(), 32'h4);
    cmd(OP_SE, 1'b1, 24'h000300, 0, 3'h5);
    check(fl(), 32'h4);
    cmd(OP_WRDI, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_FPP, 1'b1, 24'h000300, 1, 3'h0);
    check(fl(), 32'h0);
    rdm(12'h300, v);
    check(v, 32'hFF);
    $display("program test done");
  endtask

  task automatic t_prot;
    logic [31:0] v;
    @(posedge clk);
    blockProtect <= PROT_ALL_BP;
    cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_FPP, 1'b1, 24'h000400, 1, 3'h0);
    check(fl(), 32'h4);
    rdm(12'h400, v);
    check(v, 32'hFF);
    blockProtect <= 5'h01;
    cmd(OP_SE, 1'b1, 24'hFFF400, 0, 3'h0);
    check(fl(), 32'h4);
    cmd(OP_CE_A, 1'b0, 24'h0, 0, 3'h0);
    check(fl(), 32'h4);
    blockProtect <= 5'h00;
    cmd(OP_WRDI, 1'b0, 24'h0, 0, 3'h0);
    $display("protect test done");
  endtask

  task automatic t_susp;
    logic [31:0] v;
    cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_SE, 1'b1, 24'h000000, 0, 3'h0);
    // Suspend is only taken once the array work has finished
    repeat (4400) @(posedge clk);
    cmd(OP_SUSP, 1'b0, 24'h0, 0, 3'h0);
    check(fl(), 32'h1);
    cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_SE, 1'b1, 24'h000000, 0, 3'h0);
    check(32'({writeInProgress, suspendFlag}), 32'h1);
    cmd(OP_CE_B, 1'b0, 24'h0, 0, 3'h0);
    check(32'({writeInProgress, suspendFlag}), 32'h1);
    cmd(OP_WRDI, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_RESUME, 1'b0, 24'h0, 0, 3'h0);
    check(fl(), 32'h2);
    wait_idle();
    check(fl(), 32'h0);
    cmd(OP_RESUME, 1'b0, 24'h0, 0, 3'h0);
    check(fl(), 32'h0);
    // Program suspend: program commands rejected until resume
    cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_FPP, 1'b1, 24'h000500, 1, 3'h0);
    repeat (280) @(posedge clk);
    cmd(OP_SUSP, 1'b0, 24'h0, 0, 3'h0);
    check(fl(), 32'h1);
    cmd(OP_WREN, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_PP, 1'b1, 24'h000600, 1, 3'h0);
    check(fl(), 32'h5);
    cmd(OP_WRDI, 1'b0, 24'h0, 0, 3'h0);
    cmd(OP_RESUME, 1'b0, 24'h0, 0, 3'h0);
    check(fl(), 32'h2);
    wait_idle();
    rdm(12'h500, v);
    check(v, 32'hA0);
    rdm(12'h600, v);
    check(v, 32'hFF);
    $display("suspend test done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_erase();
    t_prog();
    t_prot();
    t_susp();
    wrap_up();
  end
endmodule
